// ---- hdl/req_pkg.sv ----
package req_pkg;
  // Beat geometry
  localparam int BEAT_DWORDS = 16;
  localparam int HALF_DWORDS = 8;
  localparam logic [8:0] DESC_DWORDS = 9'h004;
  localparam logic [8:0] BEAT_SPAN = 9'h010;
  localparam logic [8:0] PAIR_MAX_LEN = 9'h004;
  localparam logic [3:0] FULL_END_PTR = 4'hF;
  localparam logic [1:0] PTR_DWORD0 = 2'h0;
  localparam logic [1:0] PTR_DWORD8 = 2'h2;
  localparam logic [3:0] SECOND_BASE = 4'h8;
  // Tag placement in descriptor
  localparam int DESC_TAG_WORD = 3;
  localparam int DESC_TAG_BIT = 0;
  localparam int TAG_W = 8;
  localparam int TAG_COUNT = 256;
  // Register word offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_DESC0 = 4'h2;
  localparam logic [3:0] REG_DESC3 = 4'h5;
  localparam logic [3:0] REG_BE = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_RELEASE = 4'h8;
  localparam logic [3:0] REG_TAGLOG = 4'h9;
  // Control bits
  localparam int CTRL_STRADDLE = 0;
  localparam int CTRL_EXT_TAG = 1;
  // Command fields
  localparam int CMD_LEN_A_LSB = 0;
  localparam int CMD_NP_A = 8;
  localparam int CMD_ABORT = 9;
  localparam int CMD_LEN_B_LSB = 10;
  localparam int CMD_NP_B = 14;
  localparam int CMD_PAIR = 15;
  localparam int CMD_ABORT_BEAT_LSB = 16;
  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_FULL = 2;
  localparam int ST_TAG_A_LSB = 8;
  localparam int ST_TAG_B_LSB = 16;
  localparam int ST_LOG_CNT_LSB = 24;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TAG_A = 2'b01,
    ST_TAG_B = 2'b10,
    ST_SEND = 2'b11
  } issue_state_e;
endpackage

// ---- hdl/ext_tag_pool.sv ----
`timescale 1ns/1ps
module ext_tag_pool #(
  parameter int TAGS = req_pkg::TAG_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Allocation
  input wire logic alloc,
  output logic [req_pkg::TAG_W-1:0] free_tag,
  output logic full,
  // Release after completion
  input wire logic release_en,
  input wire logic [req_pkg::TAG_W-1:0] release_tag
);
  logic [TAGS-1:0] busy_r;
  logic [TAGS-1:0] busy_nxt;
  logic found;

  always_comb begin
    free_tag = '0;
    found = 1'b0;
    for (int i = TAGS - 1; i >= 0; i--) begin
      if (!busy_r[i]) begin
        free_tag = req_pkg::TAG_W'(i);
        found = 1'b1;
      end
    end
  end
  assign full = !found;

  always_comb begin
    busy_nxt = busy_r;
    if (release_en) begin
      busy_nxt[release_tag] = 1'b0;
    end
    // Allocation wins over release
    if (alloc && found) begin
      busy_nxt[free_tag] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= '0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
endmodule // ext_tag_pool

// ---- hdl/tag_log.sv ----
`timescale 1ns/1ps
module tag_log #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Tags from the core
  input wire logic [2*req_pkg::TAG_W-1:0] tag_in,
  input wire logic [1:0] tag_vld,
  // Software pop
  input wire logic pop,
  output logic [req_pkg::TAG_W-1:0] head,
  output logic not_empty,
  output logic [AW:0] count
);
  logic [req_pkg::TAG_W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_pop;
  logic wr0;
  logic wr1;
  logic [AW-1:0] wp1;
  logic [AW:0] room;

  assign room = (AW + 1)'(DEPTH) - cnt_r;
  assign do_pop = pop && cnt_r != '0;
  // low byte is the earlier tag
  assign wr0 = tag_vld[0] && room != '0;
  assign wr1 = tag_vld[0] && tag_vld[1] && room > (AW + 1)'(1);
  assign wp1 = wp_r + AW'(1);
  assign head = mem[rp_r];
  assign not_empty = cnt_r != '0;
  assign count = cnt_r;

  always_ff @(posedge clk) begin
    if (wr0) begin
      mem[wp_r] <= tag_in[req_pkg::TAG_W-1:0];
    end
    if (wr1) begin
      mem[wp1] <= tag_in[2*req_pkg::TAG_W-1:req_pkg::TAG_W];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(wr0) + AW'(wr1);
      rp_r <= rp_r + AW'(do_pop);
      cnt_r <= cnt_r + (AW + 1)'(wr0) + (AW + 1)'(wr1) - (AW + 1)'(do_pop);
    end
  end
endmodule // tag_log

// ---- hdl/request_issuer.sv ----
// Behaviour
// - Abort may come in any payload beat; we end the packet there, except in pair mode, where abort is ignored.
// - Abort only with valid high, held until ready; sampled on handshake.
// - No new packet starts in the beat carrying an abort.
// - First start flag set when a request starts; lane 0 or 32 (this design starts at lane 0 only).
// - First start pointer is 00 for dword 0, 10 for dword 8; this design always drives 00.
// - Second start flag only for two starts, with first end set.
// - Second start pointer is always 10; this design drives 00 when the second start flag is clear.
// - First end flag and pointer give first ending request's last dword.
// - Second end needs first end and start; pointer within 10 to 15.
// - Payload follows descriptor with no gap dwords.
// - External mode: we pick unique tags for non-posted requests and put them in the descriptor.
// - Valid stays high for the whole packet.
// - Each packet begins with a sixteen-byte descriptor.
`timescale 1ns/1ps
module request_issuer #(
  parameter int LOG_DEPTH = 16,
  parameter int LOG_AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Request stream
  output logic [511:0] request_stream_data,
  output logic [15:0] request_stream_keep,
  output logic request_stream_last,
  output logic request_stream_valid,
  input wire logic request_stream_ready,
  // Request sideband
  output logic [1:0] start_flags,
  output logic [1:0] first_start_pointer,
  output logic [1:0] second_start_pointer,
  output logic [1:0] end_flags,
  output logic [3:0] first_end_pointer,
  output logic [3:0] second_end_pointer,
  output logic [7:0] leading_byte_enables,
  output logic [7:0] trailing_byte_enables,
  output logic request_abort,
  // Allocated tags from the core
  input wire logic [15:0] allocated_tag_out,
  input wire logic [1:0] allocated_tag_valid
);
  localparam int TW = req_pkg::TAG_W;

  req_pkg::issue_state_e state_r;
  req_pkg::issue_state_e state_nxt;
  logic [1:0] ctrl_r;
  logic [31:0] cmd_r;
  logic [31:0] desc_r [4];
  logic [15:0] be_r;
  logic [TW-1:0] tag_a_r;
  logic [TW-1:0] tag_b_r;
  logic refused_r;
  logic [4:0] beat_r;
  logic [31:0] rdata_r;
  logic valid_r;
  logic [511:0] data_r;
  logic [15:0] keep_r;
  logic last_r;
  logic [1:0] sflag_r;
  logic [1:0] eflag_r;
  logic [3:0] eptr0_r;
  logic [3:0] eptr1_r;
  logic abort_r;
  logic [7:0] lbe_r;
  logic [7:0] tbe_r;

  // Command decode
  wire [8:0] len_a = 9'(cmd_r[req_pkg::CMD_LEN_A_LSB +: 8]);
  wire [8:0] len_b = 9'(cmd_r[req_pkg::CMD_LEN_B_LSB +: 4]);
  wire np_a = cmd_r[req_pkg::CMD_NP_A];
  wire np_b = cmd_r[req_pkg::CMD_NP_B];
  wire [4:0] abort_beat = cmd_r[req_pkg::CMD_ABORT_BEAT_LSB +: 5];
  wire straddle_en = ctrl_r[req_pkg::CTRL_STRADDLE];
  wire ext_mode = ctrl_r[req_pkg::CTRL_EXT_TAG];
  // pair only when both fit one half
  wire pair_mode = cmd_r[req_pkg::CMD_PAIR] && straddle_en && len_a <= req_pkg::PAIR_MAX_LEN &&
    len_b <= req_pkg::PAIR_MAX_LEN;
  wire [8:0] tot_a = len_a + req_pkg::DESC_DWORDS;
  wire [8:0] tot_b = len_b + req_pkg::DESC_DWORDS;
  wire [8:0] sent = {beat_r, 4'h0};
  wire [8:0] remain = tot_a - sent;
  wire is_final = remain <= req_pkg::BEAT_SPAN;
  // abort ends the packet in that beat
  wire abort_hit = cmd_r[req_pkg::CMD_ABORT] && !pair_mode && len_a != '0 &&
    (beat_r == abort_beat || is_final);
  wire end_beat = pair_mode || is_final || abort_hit;

  wire [31:0] desc3_a = (ext_mode && np_a) ?
    {desc_r[3][31:TW], tag_a_r} : desc_r[req_pkg::DESC_TAG_WORD];
  wire [31:0] desc3_b = (ext_mode && np_b) ?
    {desc_r[3][31:TW], tag_b_r} : desc_r[req_pkg::DESC_TAG_WORD];

  // Beat assembly
  logic [511:0] beat_data;
  logic [15:0] beat_keep;
  for (genvar g = 0; g < req_pkg::BEAT_DWORDS; g++) begin : g_dw
    wire sel_b = pair_mode && g >= req_pkg::HALF_DWORDS;
    wire [8:0] lin = pair_mode ? 9'(g % req_pkg::HALF_DWORDS) : sent + 9'(g);
    wire used = lin < (sel_b ? tot_b : tot_a);
    wire [31:0] dsc = (lin == 9'(req_pkg::DESC_TAG_WORD)) ? (sel_b ? desc3_b : desc3_a) : desc_r[lin[1:0]];
    wire [31:0] pay = 32'(lin - req_pkg::DESC_DWORDS);
    assign beat_data[g*32 +: 32] = !used ? 32'h0000_0000 : (lin < req_pkg::DESC_DWORDS ? dsc : pay);
    assign beat_keep[g] = used;
  end

  // last dword offset of first ending request
  wire [3:0] eptr0 = (is_final || pair_mode) ? 4'(tot_a - 9'h001) : req_pkg::FULL_END_PTR;
  // second end lands in dwords 11 to 15
  wire [3:0] eptr1 = req_pkg::SECOND_BASE + 4'(tot_b - 9'h001);
  // start flag in the first beat of a packet
  wire [1:0] sflag = {pair_mode, pair_mode || beat_r == '0};
  // second start only with first end
  wire [1:0] eflag = {pair_mode, end_beat};

  // External tag pool
  logic pool_alloc;
  logic [TW-1:0] pool_tag;
  logic pool_full;
  wire wr_release = sw_wr && sw_addr == req_pkg::REG_RELEASE;
  ext_tag_pool #(.TAGS(req_pkg::TAG_COUNT)) u_pool (
    .clk(clk),
    .rstn(rstn),
    .alloc(pool_alloc),
    .free_tag(pool_tag),
    .full(pool_full),
    .release_en(wr_release),
    .release_tag(sw_wdata[TW-1:0])
  );

  // Log of tags the core hands back
  logic [TW-1:0] log_head;
  logic log_ne;
  logic [LOG_AW:0] log_cnt;
  wire rd_log = sw_rd && sw_addr == req_pkg::REG_TAGLOG;
  tag_log #(.DEPTH(LOG_DEPTH), .AW(LOG_AW)) u_log (
    .clk(clk),
    .rstn(rstn),
    .tag_in(allocated_tag_out),
    .tag_vld(allocated_tag_valid),
    .pop(rd_log),
    .head(log_head),
    .not_empty(log_ne),
    .count(log_cnt)
  );

  // Handshake and sequencing
  wire load = !valid_r || request_stream_ready;
  wire idle = state_r == req_pkg::ST_IDLE;
  wire wr_cmd = sw_wr && sw_addr == req_pkg::REG_CMD && idle;
  wire need_a = ext_mode && np_a;
  wire need_b = ext_mode && np_b && pair_mode;
  wire refuse = (state_r == req_pkg::ST_TAG_A && need_a && pool_full) ||
    (state_r == req_pkg::ST_TAG_B && need_b && pool_full);
  assign pool_alloc = !pool_full && ((state_r == req_pkg::ST_TAG_A && need_a) ||
    (state_r == req_pkg::ST_TAG_B && need_b));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      req_pkg::ST_IDLE: begin
        if (wr_cmd) begin
          state_nxt = req_pkg::ST_TAG_A;
        end
      end
      req_pkg::ST_TAG_A: begin
        state_nxt = refuse ? req_pkg::ST_IDLE : req_pkg::ST_TAG_B;
      end
      req_pkg::ST_TAG_B: begin
        state_nxt = refuse ? req_pkg::ST_IDLE : req_pkg::ST_SEND;
      end
      req_pkg::ST_SEND: begin
        // next packet waits for a fresh beat
        if (load && end_beat) begin
          state_nxt = req_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Software registers
  wire [31:0] status = {3'h0, log_cnt[LOG_AW:0] == '0 ? 5'h00 : 5'(log_cnt), tag_b_r, tag_a_r,
    5'h00, pool_full, refused_r, !idle || valid_r};
  wire [31:0] rd_mux =
    (sw_addr == req_pkg::REG_CTRL) ? 32'(ctrl_r) :
    (sw_addr == req_pkg::REG_CMD) ? cmd_r :
    (sw_addr >= req_pkg::REG_DESC0 && sw_addr <= req_pkg::REG_DESC3) ? desc_r[2'(sw_addr - req_pkg::REG_DESC0)] :
    (sw_addr == req_pkg::REG_BE) ? 32'(be_r) :
    (sw_addr == req_pkg::REG_STATUS) ? status :
    (sw_addr == req_pkg::REG_TAGLOG) ? {23'h000000, log_ne, log_head} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= '0;
      cmd_r <= '0;
      be_r <= '0;
      desc_r <= '{default: 32'h0000_0000};
      rdata_r <= '0;
    end else begin
      rdata_r <= sw_rd ? rd_mux : 32'h0000_0000;
      if (sw_wr && sw_addr == req_pkg::REG_CTRL && idle) begin
        ctrl_r <= sw_wdata[1:0];
      end
      if (wr_cmd) begin
        cmd_r <= sw_wdata;
      end
      if (sw_wr && sw_addr == req_pkg::REG_BE && idle) begin
        be_r <= sw_wdata[15:0];
      end
      if (sw_wr && idle && sw_addr >= req_pkg::REG_DESC0 && sw_addr <= req_pkg::REG_DESC3) begin
        desc_r[2'(sw_addr - req_pkg::REG_DESC0)] <= sw_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= req_pkg::ST_IDLE;
      tag_a_r <= '0;
      tag_b_r <= '0;
      refused_r <= 1'b0;
      beat_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == req_pkg::ST_TAG_A && pool_alloc) begin
        tag_a_r <= pool_tag;
      end
      if (state_r == req_pkg::ST_TAG_B && pool_alloc) begin
        tag_b_r <= pool_tag;
      end
      // Refusal set wins over clear
      refused_r <= refuse || (refused_r && !(sw_wr && sw_addr == req_pkg::REG_STATUS &&
        sw_wdata[req_pkg::ST_REFUSED]));
      if (wr_cmd) begin
        beat_r <= '0;
      end else if (state_r == req_pkg::ST_SEND && load) begin
        beat_r <= beat_r + 5'h01;
      end
    end
  end

  // beat and abort held until ready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      data_r <= '0;
      keep_r <= '0;
      last_r <= 1'b0;
      sflag_r <= '0;
      eflag_r <= '0;
      eptr0_r <= '0;
      eptr1_r <= '0;
      abort_r <= 1'b0;
      lbe_r <= '0;
      tbe_r <= '0;
    end else if (load) begin
      valid_r <= state_r == req_pkg::ST_SEND;
      data_r <= beat_data;
      keep_r <= beat_keep;
      last_r <= end_beat;
      sflag_r <= sflag;
      eflag_r <= eflag;
      eptr0_r <= eptr0;
      eptr1_r <= eptr1;
      abort_r <= state_r == req_pkg::ST_SEND && abort_hit;
      // second enables in the upper half
      lbe_r <= {pair_mode ? be_r[11:8] : 4'h0, be_r[3:0]};
      tbe_r <= {pair_mode ? be_r[15:12] : 4'h0, be_r[7:4]};
    end
  end

  assign sw_rdata = rdata_r;
  assign request_stream_valid = valid_r;
  assign request_stream_data = data_r;
  assign request_stream_keep = keep_r;
  assign request_stream_last = last_r;
  assign start_flags = sflag_r;
  // first start always at dword 0
  assign first_start_pointer = req_pkg::PTR_DWORD0;
  assign second_start_pointer = sflag_r[1] ? req_pkg::PTR_DWORD8 : req_pkg::PTR_DWORD0;
  assign end_flags = eflag_r;
  assign first_end_pointer = eptr0_r;
  assign second_end_pointer = eflag_r[1] ? eptr1_r : 4'h0;
  assign leading_byte_enables = lbe_r;
  assign trailing_byte_enables = tbe_r;
  assign request_abort = abort_r;
endmodule // request_issuer

// ---- verif/req_issuer_sva.sv ----
`timescale 1ns/1ps
module req_issuer_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Stream
  input wire logic [15:0] request_stream_keep,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  input wire logic request_stream_ready,
  // Sideband
  input wire logic [1:0] start_flags,
  input wire logic [1:0] first_start_pointer,
  input wire logic [1:0] second_start_pointer,
  input wire logic [1:0] end_flags,
  input wire logic [3:0] first_end_pointer,
  input wire logic [3:0] second_end_pointer,
  input wire logic request_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire vld = request_stream_valid;
  wire [16:0] end_mask = (17'h00001 << (first_end_pointer + 5'h01)) - 17'h00001;
  sequence s_held; vld && !request_stream_ready; endsequence
  sequence s_mid; vld && request_stream_ready && !request_stream_last; endsequence
  a_abort_valid: assert property (request_abort |-> vld)
    else $error("abort without valid");
  a_abort_held: assert property (s_held ##0 request_abort |=> request_abort)
    else $error("abort dropped before ready");
  a_valid_through: assert property (s_mid |=> vld && !start_flags[0])
    else $error("valid dropped or restart inside packet");
  a_abort_ends: assert property (vld && request_abort |-> request_stream_last && end_flags[0] && !start_flags[1])
    else $error("abort beat not closing packet");
  a_first_ptr: assert property (vld && start_flags[0] |-> first_start_pointer inside {2'h0, 2'h2})
    else $error("bad first start pointer");
  a_desc_first: assert property (vld && start_flags[0] |-> request_stream_keep[3:0] == 4'hF)
    else $error("descriptor lanes not kept");
  a_second_start: assert property (vld && start_flags[1] |-> start_flags[0] && end_flags[0]
    && second_start_pointer == 2'h2 && first_end_pointer <= 4'h7)
    else $error("bad second start");
  a_second_end: assert property (vld && end_flags[1] |-> start_flags[0] && end_flags[0]
    && second_end_pointer inside {[4'hA:4'hF]})
    else $error("bad second end");
  a_end_ptr: assert property (vld && request_stream_last && !end_flags[1] |->
    end_flags[0] && {1'b0, request_stream_keep} == end_mask)
    else $error("end pointer and keep disagree");
  a_held_stable: assert property (s_held |=> vld && $stable(request_stream_keep) && $stable(request_stream_last))
    else $error("held beat changed");
endmodule // req_issuer_sva
bind request_issuer req_issuer_sva u_sva (.*);

// ---- verif/core_model.sv ----
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request stream
  input wire logic [511:0] request_stream_data,
  input wire logic [15:0] request_stream_keep,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  output logic request_stream_ready,
  // Sideband
  input wire logic [1:0] start_flags,
  input wire logic [3:0] first_end_pointer,
  input wire logic [7:0] leading_byte_enables,
  input wire logic [7:0] trailing_byte_enables,
  input wire logic request_abort,
  // Allocated tags
  output logic [15:0] allocated_tag_out,
  output logic [1:0] allocated_tag_valid,
  // Bench control
  input wire logic slow,
  input wire logic straddle,
  input wire logic ext_mode,
  // Observations
  output logic [7:0] pkt_beats,
  output logic [15:0] last_keep,
  output logic [3:0] last_eptr,
  output logic [7:0] null_cnt,
  output logic [15:0] pkts,
  output logic [7:0] be_b,
  output logic [7:0] desc_tag
);
  logic [7:0] tag_q[$];
  logic [7:0] next_tag;
  logic [8:0] pending;
  logic [2:0] phase;
  logic aborted, in_pkt, ab;
  wire take = request_stream_valid && request_stream_ready;
  assign request_stream_ready = !(!ext_mode && pending == 9'h100) && (!slow || phase[0]);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {pkt_beats, null_cnt, be_b, desc_tag} <= 32'h0;
      {last_keep, pkts} <= 32'h0;
      {last_eptr, next_tag, pending, phase, aborted, in_pkt} <= 26'h0;
      allocated_tag_out <= 16'h0000;
      allocated_tag_valid <= 2'h0;
      tag_q.delete();
    end else begin
      phase <= phase + 3'h1;
      allocated_tag_valid <= 2'h0;
      if (tag_q.size() > 0 && phase[1:0] == 2'h3) begin
        allocated_tag_out[7:0] <= tag_q.pop_front();
        allocated_tag_valid <= 2'h1;
        if (straddle && tag_q.size() > 0) begin
          allocated_tag_out[15:8] <= tag_q.pop_front();
          allocated_tag_valid <= 2'h3;
        end
      end
      if (in_pkt && !request_stream_valid) begin
        null_cnt <= null_cnt + 8'h01;
        in_pkt <= 1'b0;
      end
      if (take) begin
        ab = aborted || request_abort;
        pkt_beats <= start_flags[0] ? 8'h01 : pkt_beats + 8'h01;
        if (start_flags[0]) desc_tag <= request_stream_data[103:96];
        if (start_flags[1]) be_b <= {trailing_byte_enables[7:4], leading_byte_enables[7:4]};
        if (start_flags[0] && !ext_mode) begin
          tag_q.push_back(next_tag);
          if (start_flags[1]) tag_q.push_back(next_tag + 8'h01);
          next_tag <= next_tag + 8'h01 + start_flags[1];
          pending <= pending + 9'h001 + start_flags[1];
        end
        in_pkt <= !request_stream_last;
        aborted <= ab && !request_stream_last;
        if (request_stream_last) begin
          pkts <= pkts + 16'h0001;
          last_keep <= request_stream_keep;
          last_eptr <= first_end_pointer;
          if (ab) null_cnt <= null_cnt + 8'h01;
        end
      end
    end
  end
endmodule // core_model

// ---- verif/request_issuer_tb.sv ----
`timescale 1ns/1ps
module request_issuer_tb;
  typedef struct {logic [7:0] len; logic [7:0] beats; logic [15:0] keep; logic [3:0] eptr;} row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic slow = 1'b0;
  logic straddle = 1'b0;
  logic ext_mode = 1'b0;
  logic [31:0] sw_rdata, d;
  logic [511:0] request_stream_data;
  logic [15:0] request_stream_keep, allocated_tag_out, pkts, last_keep, p0;
  logic request_stream_last, request_stream_valid, request_stream_ready, request_abort;
  logic [1:0] start_flags, first_start_pointer, second_start_pointer, end_flags, allocated_tag_valid;
  logic [3:0] first_end_pointer, second_end_pointer, last_eptr;
  logic [7:0] leading_byte_enables, trailing_byte_enables, pkt_beats, null_cnt, be_b, desc_tag, tag_n, t0;
  logic [255:0] seen = '0;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  row_s rows[6] = '{'{8'h00, 8'h01, 16'h000F, 4'h3}, '{8'h0C, 8'h01, 16'hFFFF, 4'hF},
    '{8'h0D, 8'h02, 16'h0001, 4'h0}, '{8'h14, 8'h02, 16'h00FF, 4'h7},
    '{8'h3C, 8'h04, 16'hFFFF, 4'hF}, '{8'h40, 8'h05, 16'h000F, 4'h3}};
  request_issuer u_request_issuer (.*);
  core_model u_core_model (.*);
  always #5 clk = ~clk;
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    v = sw_rdata;
  endtask
  task automatic run_cmd(input logic [31:0] c);
    wr(req_pkg::REG_CMD, c);
    for (int k = 0; k < 100; k++) begin
      rd(req_pkg::REG_STATUS, d);
      if (d[req_pkg::ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic pop_tag();
    for (int k = 0; k < 20; k++) begin
      rd(req_pkg::REG_STATUS, d);
      if (d[28:24] !== 5'h00) break;
    end
    rd(req_pkg::REG_TAGLOG, d);
    check("tag", {23'h0, 1'b1, tag_n}, d);
    tag_n = tag_n + 8'h01;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    tag_n = 8'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(req_pkg::REG_STATUS, d);
    check("status reset", 32'h0, d);
    rd(4'hF, d);
    check("unmapped", 32'h0, d);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      run_cmd({23'h0, 1'b1, rows[i].len});
      check("beats", 32'(rows[i].beats), 32'(pkt_beats));
      check("keep", 32'(rows[i].keep), 32'(last_keep));
      check("end ptr", 32'(rows[i].eptr), 32'(last_eptr));
      pop_tag();
      $display("row %0d done", i);
    end
    slow <= 1'b1;
    t0 = null_cnt;
    run_cmd(32'h0001_0328);
    check("abort beats", 32'h2, 32'(pkt_beats));
    check("nullified", 32'(t0 + 8'h01), 32'(null_cnt));
    pop_tag();
    $display("abort test done");
    wr(req_pkg::REG_CTRL, 32'h1);
    straddle <= 1'b1;
    wr(req_pkg::REG_BE, 32'h0000_5AFF);
    run_cmd(32'h0000_CD02);
    check("pair beats", 32'h1, 32'(pkt_beats));
    check("pair end ptr", 32'h5, 32'(last_eptr));
    check("second enables", 32'h5A, 32'(be_b));
    pop_tag();
    pop_tag();
    $display("pair test done");
    slow <= 1'b0;
    straddle <= 1'b0;
    ext_mode <= 1'b1;
    wr(req_pkg::REG_CTRL, 32'h2);
    for (int i = 0; i < 256; i++) begin
      run_cmd(32'h0000_0100);
      check("unique tag", 32'h0, 32'(seen[desc_tag]));
      seen[desc_tag] = 1'b1;
    end
    rd(req_pkg::REG_STATUS, d);
    check("pool full", 32'h1, 32'(d[req_pkg::ST_FULL]));
    p0 = pkts;
    run_cmd(32'h0000_0100);
    rd(req_pkg::REG_STATUS, d);
    check("refused", 32'h1, 32'(d[req_pkg::ST_REFUSED]));
    check("no beat", 32'(p0), 32'(pkts));
    wr(req_pkg::REG_RELEASE, 32'h0000_005C);
    wr(req_pkg::REG_STATUS, 32'h0000_0002);
    run_cmd(32'h0000_0100);
    check("reused tag", 32'h5C, 32'(desc_tag));
    $display("external tag test done");
    give_verdict();
  end
endmodule // request_issuer_tb
